// file: shared/ccsel_pkg.sv
// package: constants and types for the core clock source selector
package ccsel_pkg;

  localparam longint CLK_HZ        = 40_000_000;
  localparam longint INT_OSC_HZ    = 12_000_000;
  localparam int     PHASE_W       = 16;
  // phase increment per system clock for the nominal internal rate
  localparam logic [PHASE_W-1:0] PHASE_STEP = PHASE_W'(
    (INT_OSC_HZ * 64'h0000_0000_0001_0000 + CLK_HZ / 2) / CLK_HZ);
  localparam int     TIMEOUT_TICKS = 32;
  localparam int     WD_W          = 6;
  localparam int     TB_W          = 16;
  localparam logic [7:0]      TRIM_RST = 8'h00;
  localparam logic [TB_W-1:0] TB_RST   = 16'h0000;

  typedef enum logic [1:0] {
    SRC_INT,
    SRC_TO_EXT,
    SRC_EXT,
    SRC_TO_INT
  } ccsel_src_e;

  typedef struct packed {
    logic [7:0] trim;
    logic       loaded;
  } ccsel_cfg_s;

endpackage

// file: hw/ccsel_top.sv
// core clock source selector with external clock failover
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////
// Contract
// RULE1 - reset loads all configuration defaults; trim comes from OTP.
// RULE2 - selected core clock alone drives the shared timebase counter.
// RULE3 - system wanting internal clock holds clock input low forever.
// RULE4 - internal oscillator runs near 12 MHz with OTP trim applied.
// RULE5 - first rising edge on clock input switches core to external.
// RULE6 - 32 internal ticks without external activity revert to internal.
// RULE7 - external clock 8 to 13.4 MHz, max 16 MHz, near 50% duty.
// RULE8 - during supply reset all digital inputs held low by controller; the bench drives I_OTP_TRIM with the trim value during reset.
// RULE9 - source changeover never shortens a high or low core phase.
// RULE10 - after fallback the selector re-arms for the next rising edge.
module ccsel_top
  import ccsel_pkg::*;
(
  input  wire logic             I_CLK,
  input  wire logic             I_RESET,
  input  wire logic             I_EXT_CLK,
  input  wire logic [7:0]       I_OTP_TRIM,
  output logic                  O_CORE_CLK,
  output logic                  O_CORE_TICK,
  output logic                  O_SRC_EXT,
  output logic [TB_W-1:0]       O_TIMEBASE,
  output ccsel_cfg_s            O_CFG
);

  ////////////////////////////////////////////////////////////////////////////
  // configuration load
  ccsel_cfg_s cfg_q;
  ccsel_cfg_s cfg_d;

  always_comb begin
    cfg_d = cfg_q;
    if (!cfg_q.loaded) begin
      // trim sampled one cycle after release, never under reset
      cfg_d.trim   = I_OTP_TRIM;                          // [RULE1]
      cfg_d.loaded = 1'b1;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      cfg_q <= '{trim: TRIM_RST, loaded: 1'b0};           // [RULE1]
    end else begin
      cfg_q <= cfg_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // internal oscillator as phase accumulator
  logic [PHASE_W-1:0] acc_q;
  logic [PHASE_W-1:0] acc_d;
  logic               int_lvl;
  logic               int_prev_q;
  logic               int_rise;

  always_comb begin
    acc_d = acc_q + PHASE_STEP
          + {{(PHASE_W-8){cfg_q.trim[7]}}, cfg_q.trim};   // [RULE4]
  end

  assign int_lvl  = acc_q[PHASE_W-1];
  assign int_rise = int_lvl & ~int_prev_q;

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      acc_q      <= '0;
      int_prev_q <= 1'b0;
    end else begin
      acc_q      <= acc_d;
      int_prev_q <= int_lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // external clock pin: three stages, change accepted when last two agree
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic ext_q;
  logic ext_prev_q;
  logic ext_d;
  logic ext_rise;
  logic ext_act;

  always_comb begin
    ext_d = (s2_q == s3_q) ? s3_q : ext_q;
  end

  assign ext_rise = ext_q & ~ext_prev_q;
  assign ext_act  = ext_q ^ ext_prev_q;

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      s1_q       <= 1'b0;
      s2_q       <= 1'b0;
      s3_q       <= 1'b0;
      ext_q      <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      s1_q       <= I_EXT_CLK;
      s2_q       <= s1_q;
      s3_q       <= s2_q;
      ext_q      <= ext_d;
      ext_prev_q <= ext_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source selection and watchdog
  ccsel_src_e      state_q;
  ccsel_src_e      state_d;
  logic [WD_W-1:0] wd_q;
  logic [WD_W-1:0] wd_d;
  logic            core_q;
  logic            core_d;
  logic            timeout;

  assign timeout = int_rise && !ext_act
                && (wd_q == WD_W'(TIMEOUT_TICKS - 1));

  always_comb begin
    state_d = state_q;
    wd_d    = wd_q;
    core_d  = core_q;
    // watchdog counts internal ticks, cleared by any external edge
    if (state_q == SRC_INT || ext_act) begin
      wd_d = '0;
    end else if (int_rise) begin
      wd_d = wd_q + WD_W'(1);                             // [RULE6]
    end
    unique case (state_q)
      SRC_INT: begin
        core_d = int_lvl;
        if (ext_rise) begin
          state_d = SRC_TO_EXT;                           // [RULE5] [RULE10]
        end
      end
      SRC_TO_EXT: begin
        core_d = int_lvl;
        if (timeout) begin
          state_d = SRC_INT;                              // [RULE6]
        end else if (!int_lvl && !ext_q) begin
          // both low: handover cannot cut a phase short
          state_d = SRC_EXT;                              // [RULE9]
          core_d  = 1'b0;
        end
      end
      SRC_EXT: begin
        core_d = ext_q;
        if (timeout) begin
          state_d = SRC_TO_INT;                           // [RULE6]
        end
      end
      SRC_TO_INT: begin
        // dead source may stretch the phase, never shorten it
        core_d = ext_q;
        if (!int_lvl) begin
          state_d = SRC_INT;                              // [RULE9]
          core_d  = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      state_q <= SRC_INT;
      wd_q    <= '0;
      core_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      wd_q    <= wd_d;
      core_q  <= core_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared timebase for chopper, blanking, power-down and step generator
  logic            core_prev_q;
  logic            core_rise;
  logic [TB_W-1:0] tb_q;
  logic [TB_W-1:0] tb_d;

  assign core_rise = core_q & ~core_prev_q;

  always_comb begin
    tb_d = core_rise ? tb_q + TB_W'(1) : tb_q;            // [RULE2]
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      core_prev_q <= 1'b0;
      tb_q        <= TB_RST;
    end else begin
      core_prev_q <= core_q;
      tb_q        <= tb_d;
    end
  end

  assign O_CORE_CLK  = core_q;
  assign O_CORE_TICK = core_rise;
  assign O_SRC_EXT   = (state_q == SRC_EXT) || (state_q == SRC_TO_INT);
  assign O_TIMEBASE  = tb_q;
  assign O_CFG       = cfg_q;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  sequence s_fallback;
    (state_q == SRC_TO_INT) ##1 (state_q == SRC_INT);
  endsequence

  sequence s_handover;
    (state_q == SRC_TO_EXT) ##1 (state_q == SRC_EXT);
  endsequence

  property p_cfg_load;
    @(posedge I_CLK) $fell(I_RESET) |-> ##[0:2] cfg_q.loaded;
  endproperty
  a_cfg_load: assert property (p_cfg_load) // [RULE1]
    else $error("trim not loaded after reset");

  property p_tb_step;
    @(posedge I_CLK) disable iff (I_RESET)
      core_rise |=> (tb_q == $past(tb_q) + TB_W'(1));
  endproperty
  a_tb_step: assert property (p_tb_step) // [RULE2]
    else $error("timebase missed a core tick");

  property p_tb_hold;
    @(posedge I_CLK) disable iff (I_RESET)
      !core_rise |=> (tb_q == $past(tb_q));
  endproperty
  a_tb_hold: assert property (p_tb_hold) // [RULE2]
    else $error("timebase moved without core tick");

  property p_osc_rate;
    @(posedge I_CLK) disable iff (I_RESET)
      int_rise |=> (!int_rise) [*2];
  endproperty
  a_osc_rate: assert property (p_osc_rate) // [RULE4]
    else $error("internal oscillator too fast");

  property p_sw_ext;
    @(posedge I_CLK) disable iff (I_RESET)
      (state_q == SRC_INT) && ext_rise |=> (state_q == SRC_TO_EXT);
  endproperty
  a_sw_ext: assert property (p_sw_ext) // [RULE5]
    else $error("external edge did not arm switch");

  property p_timeout;
    @(posedge I_CLK) disable iff (I_RESET)
      (state_q == SRC_EXT) && timeout |=> (state_q == SRC_TO_INT)
        ##[1:8] (state_q == SRC_INT);
  endproperty
  a_timeout: assert property (p_timeout) // [RULE6]
    else $error("no fallback after external clock loss");

  property p_glitch;
    @(posedge I_CLK) disable iff (I_RESET)
      // ext may rise right after the swap; judge the levels it swapped on
      s_handover |-> !core_q && !$past(ext_q) && !$past(int_lvl);
  endproperty
  a_glitch: assert property (p_glitch) // [RULE9]
    else $error("core clock glitched at handover");

  property p_rearm;
    @(posedge I_CLK) disable iff (I_RESET)
      s_fallback ##[1:16] ((state_q == SRC_INT) && ext_rise)
        |=> (state_q == SRC_TO_EXT);
  endproperty
  a_rearm: assert property (p_rearm) // [RULE10]
    else $error("selector not re-armed after fallback");

endmodule

// file: bench/ccsel_ext_src.sv
// partner model: external clock source on the clock input pin
`timescale 1ns/100ps

module ccsel_ext_src (
  input  wire logic       i_clk,
  input  wire logic       i_en,
  input  wire logic [3:0] i_half,
  output logic            o_ext
);
  logic [3:0] cnt_q;

  // enable starts low, so the first edge parks pin and count

  always_ff @(posedge i_clk) begin
    if (!i_en) begin
      // a stopped source parks the pin low, keeping internal chosen
      o_ext <= 1'b0;
      cnt_q <= 4'h0;
    end else if (cnt_q + 4'h1 >= i_half) begin
      // equal halves give a near 50% duty at 10 MHz
      o_ext <= ~o_ext;
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule

// file: bench/clock_source_select_failover_tb.sv
// testbench for the core clock source selector
`timescale 1ns/100ps

module clock_source_select_failover_tb
  import ccsel_pkg::*;
;
  logic            I_CLK = 1'b0;
  logic            I_RESET = 1'b1;
  logic [7:0]      I_OTP_TRIM = 8'h00;
  logic            ext_en = 1'b0;
  logic            I_EXT_CLK;
  logic            O_CORE_CLK;
  logic            O_CORE_TICK;
  logic            O_SRC_EXT;
  logic [TB_W-1:0] O_TIMEBASE;
  ccsel_cfg_s      O_CFG;
  int              failures = 0;
  int              samples_checked = 0;

  always #12.5 I_CLK = ~I_CLK;

  ccsel_ext_src i_src (
    .i_clk  (I_CLK),
    .i_en   (ext_en),
    .i_half (4'h2),
    .o_ext  (I_EXT_CLK)
  );

  ccsel_top i_dut (
    .I_CLK       (I_CLK),
    .I_RESET     (I_RESET),
    .I_EXT_CLK   (I_EXT_CLK),
    .I_OTP_TRIM  (I_OTP_TRIM),
    .O_CORE_CLK  (O_CORE_CLK),
    .O_CORE_TICK (O_CORE_TICK),
    .O_SRC_EXT   (O_SRC_EXT),
    .O_TIMEBASE  (O_TIMEBASE),
    .O_CFG       (O_CFG)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input logic [31:0] got, input int lo, input int hi);
    samples_checked++;
    if ($isunknown(got) || got < lo || got > hi) begin
      failures++;
      $display("Error at %0t: %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask

  // settle 1 ns past the edge so registered outputs have landed
  task automatic step;
    @(posedge I_CLK);
    #1;
  endtask

  task automatic count_ticks(input int n, output int t, output int h);
    t = 0;
    h = 0;
    repeat (n) begin
      step();
      if (O_CORE_TICK === 1'b1)
        t++;
      if (O_CORE_CLK === 1'b1)
        h++;
    end
  endtask

  task automatic wait_src(input logic v, input int lim, output int w);
    w = 0;
    while (O_SRC_EXT !== v && w < lim) begin
      step();
      w++;
    end
  endtask

  // drive the source enable on an edge, then look only once settled
  task automatic set_en(input logic v);
    @(posedge I_CLK);
    ext_en <= v;
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset(input logic [7:0] trim);
    @(posedge I_CLK);
    I_RESET    <= 1'b1;
    ext_en     <= 1'b0; // external clock input low while in reset; trim driven
    I_OTP_TRIM <= trim;
    repeat (8) step();
    chk(O_TIMEBASE, 16'h0000);
    chk(16'(O_CFG), 16'h0000);
    chk(16'(O_SRC_EXT), 16'h0000);
    @(posedge I_CLK);
    I_RESET <= 1'b0;
    repeat (2) step();
    chk(16'(O_CFG), 16'({trim, 1'b1}));
  endtask

  task automatic t_internal;
    int t;
    int h;
    logic [15:0] s;
    s = O_TIMEBASE;
    // 400 cycles at 40 MHz hold about 120 internal periods
    count_ticks(400, t, h);
    chk_rng(t, 116, 124);
    chk_rng(h, 190, 210);
    chk(16'(O_SRC_EXT), 16'h0000);
    step();
    chk_rng(32'(O_TIMEBASE - s), t - 1, t + 1);
  endtask

  task automatic t_external;
    int w;
    int t;
    int h;
    set_en(1'b1);
    wait_src(1'b1, 20, w);
    chk_rng(w, 3, 19);
    repeat (20) step();
    count_ticks(400, t, h);
    chk_rng(t, 98, 102);
    chk_rng(h, 196, 204);
    // 32 internal ticks are about 107 system cycles
    set_en(1'b0);
    wait_src(1'b0, 200, w);
    chk_rng(w, 95, 140);
    set_en(1'b1);
    wait_src(1'b1, 20, w);
    chk_rng(w, 3, 19);
    set_en(1'b0);
    wait_src(1'b0, 200, w);
    chk_rng(w, 95, 140);
  endtask

  initial begin
    #(25 * 20000);
    failures++;
    final_report();
  end

  initial begin
    t_reset(8'h5A);
    t_internal();
    t_external();
    t_reset(8'hA6);
    t_internal();
    final_report();
  end
endmodule
